// >>> src/diag_release_cmd.sv
`timescale 1ns/1ps
`include "diag_cmd_regs.svh"
// Functional notes
// RQ1: With page-code-valid set, return the page named by the page code; listed pages 3Fh and 42h give check instead.
// RQ2: With it clear, return the page chosen by the last send diagnostic.
// RQ3: Allocation length zero is legal and transfers nothing.
// RQ4: Data-in ends at end of data or at allocation length.
// RQ5: Supported page list: length 04h, pages 0h, 3Fh, 40h, 42h ascending.
// RQ6: Translate page length is 02h when reserved area, else 0Ah.
// RQ7: Echo supplied address format as a 3-bit code.
// RQ8: Block formats translate to physical, physical to long block; else check.
// RQ9: Set reserved-area flag for inaccessible translated sectors.
// RQ10: Set alternate-sector flag for spare sectors pointing to reassigned ones.
// RQ11: Alternate-track flag is unused and reads zero.
// RQ12: Physical result: cylinder bytes 6-8, head 9, sector bytes 10-13.
// RQ13: Cached-only addresses return invalid cylinder, head and sector.
// RQ14: Release with no reservation gives good status, state unchanged.
// RQ15: Nonzero third-party bit gives check, illegal request, invalid field.
// RQ16: Third-party id and reservation id fields are ignored.
// RQ17: Initiator keeps the extent bit zero.
// RQ18: Address arrives by send diagnostic, result read back by page 40h.
// RQ19: Unsupported page with page-code-valid gives check, invalid field.
module diag_release_cmd
   import diag_cmd_pkg::*;
#(
   parameter int ALLOC_W = 16
)(
   input  wire logic               clock,
   input  wire logic               reset,
   input  wire logic               cmd_valid,
   input  wire logic [7:0]         cdb_opcode,
   input  wire logic [7:0]         cdb_byte1,
   input  wire logic [7:0]         cdb_page,
   input  wire logic [ALLOC_W-1:0] cdb_alloc_len,
   input  wire logic               sd_valid,
   input  wire logic [7:0]         sd_page,
   input  wire logic [2:0]         sd_supplied_fmt,
   input  wire logic [2:0]         sd_translate_fmt,
   input  wire logic [63:0]        sd_supplied_addr,
   input  wire logic               xl_valid,
   input  wire logic               xl_inaccessible,
   input  wire logic               xl_spare_reassigned,
   input  wire logic               xl_in_nv_cache,
   input  wire logic [63:0]        xl_addr,
   input  wire logic               holds_reservation,
   output logic                    cmd_ready,
   output logic                    din_valid,
   output logic      [7:0]         din_data,
   input  wire logic               din_ready,
   output logic                    status_valid,
   output logic      [7:0]         status_code,
   output logic      [3:0]         sense_key,
   output logic      [7:0]         sense_asc,
   output logic                    release_req,
   output logic                    xl_req,
   output logic      [63:0]        xl_req_addr,
   output logic      [2:0]         xl_req_fmt
);
   ////////////////////////////////////////////////////////////////////
   cmd_state_t         state_q;
   logic [7:0]         page_q;
   logic [ALLOC_W-1:0] remain_q;
   logic [3:0]         index_q;
   logic [4:0]         avail;
   logic [7:0]         rom_data;
   logic [7:0]         sd_page_q;
   logic [2:0]         sup_fmt_q;
   logic [2:0]         xl_fmt_q;
   logic               ra_q;
   logic               alternate_sector_flag_q;
   logic [63:0]        xaddr_q;
   logic               check_q;
   logic [7:0]         sel_page;
   logic               pair_ok;

   function automatic logic fmt_pair_ok(input logic [2:0] s,
                                        input logic [2:0] t);
      logic blk;
      logic phy;
      blk = (s == `FMT_SHORT_BLOCK) || (s == `FMT_LONG_BLOCK);
      phy = (s == `FMT_BYTES_INDEX) || (s == `FMT_PHYS_SECTOR);
      fmt_pair_ok = (blk && ((t == `FMT_BYTES_INDEX) ||
                             (t == `FMT_PHYS_SECTOR))) ||
                    (phy && (t == `FMT_LONG_BLOCK));
   endfunction : fmt_pair_ok

   function automatic logic page_known(input logic [7:0] p);
      page_known = (p == `PAGE_SUPPORTED) || (p == `PAGE_TRANSLATE);
   endfunction : page_known

   ////////////////////////////////////////////////////////////////////
   // Last send diagnostic parameters; translation request goes out one cycle later
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         sd_page_q <= 8'h00;
         sup_fmt_q <= 3'h0;
         xl_fmt_q  <= 3'h0;
      end else if (sd_valid) begin                   // see RQ18
         sd_page_q <= sd_page;
         sup_fmt_q <= sd_supplied_fmt;
         xl_fmt_q  <= sd_translate_fmt;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         xl_req      <= 1'b0;
         xl_req_addr <= 64'h0;
         xl_req_fmt  <= 3'h0;
      end else begin
         xl_req <= sd_valid && fmt_pair_ok(sd_supplied_fmt,
                                           sd_translate_fmt);
         if (sd_valid) begin
            xl_req_addr <= sd_supplied_addr;
            xl_req_fmt  <= sd_translate_fmt;
         end
      end
   end

   // Translation result from the media layer
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         ra_q    <= 1'b0;
         alternate_sector_flag_q  <= 1'b0;
         xaddr_q <= 64'h0;
      end else if (xl_valid) begin
         ra_q   <= xl_inaccessible;                  // see RQ9
         alternate_sector_flag_q <= xl_spare_reassigned;              // see RQ10
         // Data only in cache has no place on media yet
         xaddr_q <= xl_in_nv_cache ? {64{1'b1}} : xl_addr; // see RQ13
      end
   end

   ////////////////////////////////////////////////////////////////////
   // see RQ1, RQ2
   assign sel_page = cdb_byte1[`PCV_BIT] ? cdb_page : sd_page_q;
   assign pair_ok  = fmt_pair_ok(sup_fmt_q, xl_fmt_q);
   assign cmd_ready = (state_q == ST_IDLE);

   diag_page_rom u_rom (
      .page                  (page_q),
      .index                 (index_q),
      .supplied_fmt          (sup_fmt_q),
      .translate_fmt         (xl_fmt_q),
      .reserved_area_flag    (ra_q),
      .alternate_sector_flag (alternate_sector_flag_q),
      .translated_addr       (xaddr_q),
      .data                  (rom_data),
      .avail                 (avail)
   );

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_q     <= ST_IDLE;
         page_q      <= 8'h00;
         remain_q    <= '0;
         index_q     <= 4'h0;
         check_q     <= 1'b0;
         release_req <= 1'b0;
      end else begin
         release_req <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (cmd_valid) begin
                  index_q <= 4'h0;
                  page_q  <= sel_page;
                  remain_q <= cdb_alloc_len;
                  check_q <= 1'b0;
                  state_q <= ST_STAT;
                  if (cdb_opcode == `OP_RECV_DIAG) begin
                     if (!page_known(sel_page))       // see RQ19
                        check_q <= 1'b1;
                     else if (sel_page == `PAGE_TRANSLATE && !pair_ok)
                        check_q <= 1'b1;              // see RQ8
                     else if (cdb_alloc_len != '0)    // see RQ3
                        state_q <= ST_DATA;
                  end else if (cdb_opcode == `OP_RELEASE6 ||
                               cdb_opcode == `OP_RELEASE10) begin
                     // Id fields are never looked at     see RQ16
                     if (cdb_byte1[`THIRD_PARTY_BIT]) // see RQ15
                        check_q <= 1'b1;
                     else
                        release_req <= holds_reservation; // see RQ14
                  end else begin
                     check_q <= 1'b1;
                  end
               end
            end
            ST_DATA: begin
               // Index moves only on a byte the initiator really took
               if (din_valid && din_ready) begin
                  index_q  <= index_q + 4'h1;
                  remain_q <= remain_q - 1'b1;
                  // see RQ4
                  if ({1'b0, index_q} + 5'h1 >= avail ||
                      remain_q == {{(ALLOC_W-1){1'b0}}, 1'b1})
                     state_q <= ST_STAT;
               end
            end
            ST_STAT: state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         din_data <= 8'h00;
      else
         din_data <= rom_data;
   end

   // Data follows the index by one cycle, so valid waits for it
   logic din_live_q;
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         din_live_q <= 1'b0;
      else
         din_live_q <= (state_q == ST_DATA) && !(din_valid && din_ready);
   end
   assign din_valid = din_live_q;

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         status_valid <= 1'b0;
         status_code  <= `STATUS_GOOD;
         sense_key    <= 4'h0;
         sense_asc    <= 8'h00;
      end else begin
         status_valid <= (state_q == ST_STAT);
         if (state_q == ST_STAT) begin
            status_code <= check_q ? `STATUS_CHECK : `STATUS_GOOD;
            sense_key   <= check_q ? `SENSE_ILLEGAL : 4'h0;
            sense_asc   <= check_q ? `ASC_INVALID_CDB : 8'h00;
         end
      end
   end
endmodule : diag_release_cmd

// >>> src/diag_cmd_regs.svh
`ifndef DIAG_CMD_REGS_SVH
`define DIAG_CMD_REGS_SVH
`define OP_RECV_DIAG      8'h1c
`define OP_RELEASE6       8'h17
`define OP_RELEASE10      8'h57
`define PAGE_SUPPORTED    8'h00
`define PAGE_JITTER       8'h3f
`define PAGE_TRANSLATE    8'h40
`define PAGE_REBUILD      8'h42
`define LEN_SUPPORTED     8'h04
`define LEN_XLATE_RESV    8'h02
`define LEN_XLATE_FULL    8'h0a
`define FMT_SHORT_BLOCK   3'h0
`define FMT_LONG_BLOCK    3'h3
`define FMT_BYTES_INDEX   3'h4
`define FMT_PHYS_SECTOR   3'h5
`define PCV_BIT           0
`define THIRD_PARTY_BIT   4
`define EXTENT_BIT        0
`define STATUS_GOOD       8'h00
`define STATUS_CHECK      8'h02
`define SENSE_ILLEGAL     4'h5
`define ASC_INVALID_CDB   8'h24
`define PAGE_BYTES        14
`endif

// >>> src/diag_cmd_pkg.sv
package diag_cmd_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DATA = 3'b001,
      ST_STAT = 3'b011
   } cmd_state_t;
endpackage : diag_cmd_pkg

// >>> src/diag_page_rom.sv
`timescale 1ns/1ps
`include "diag_cmd_regs.svh"
module diag_page_rom
   import diag_cmd_pkg::*;
(
   input  wire logic [7:0]  page,
   input  wire logic [3:0]  index,
   input  wire logic [2:0]  supplied_fmt,
   input  wire logic [2:0]  translate_fmt,
   input  wire logic        reserved_area_flag,
   input  wire logic        alternate_sector_flag,
   input  wire logic [63:0] translated_addr,
   output logic      [7:0]  data,
   output logic      [4:0]  avail
);
   always_comb begin
      data  = 8'h00;
      avail = 5'h00;
      if (page == `PAGE_SUPPORTED) begin
         avail = 5'h08;
         case (index)
            4'h0: data = `PAGE_SUPPORTED;
            4'h3: data = `LEN_SUPPORTED;          // see RQ5
            4'h4: data = `PAGE_SUPPORTED;
            4'h5: data = `PAGE_JITTER;
            4'h6: data = `PAGE_TRANSLATE;
            4'h7: data = `PAGE_REBUILD;
            default: data = 8'h00;
         endcase
      end else begin
         // Reserved area trims the page to the format bytes only
         avail = reserved_area_flag ? 5'h06 : 5'h0e;
         case (index)
            4'h0: data = `PAGE_TRANSLATE;
            4'h3: data = reserved_area_flag ? `LEN_XLATE_RESV
                                            : `LEN_XLATE_FULL; // see RQ6
            4'h4: data = {5'h00, supplied_fmt};                // see RQ7
            // Alternate-track bit stays zero
            4'h5: data = {reserved_area_flag, alternate_sector_flag,
                          1'b0, 2'b00, translate_fmt}; // see RQ9, RQ10, RQ11
            default: begin
               if (index >= 4'h6)                            // see RQ12
                  data = translated_addr[8*(13-index) +: 8];
               else
                  data = 8'h00;
            end
         endcase
      end
   end
endmodule : diag_page_rom

// >>> dv/diag_release_props.sv
`timescale 1ns/1ps
`include "diag_cmd_regs.svh"
module diag_release_props
   import diag_cmd_pkg::*;
#(
   parameter int ALLOC_W = 16
)(
   input wire logic               clock,
   input wire logic               reset,
   input wire logic               cmd_valid,
   input wire logic               cmd_ready,
   input wire logic [7:0]         cdb_opcode,
   input wire logic [7:0]         cdb_byte1,
   input wire logic [7:0]         cdb_page,
   input wire logic [ALLOC_W-1:0] cdb_alloc_len,
   input wire logic               sd_valid,
   input wire logic [2:0]         sd_supplied_fmt,
   input wire logic [2:0]         sd_translate_fmt,
   input wire logic               holds_reservation,
   input wire logic               din_valid,
   input wire logic               status_valid,
   input wire logic [7:0]         status_code,
   input wire logic [3:0]         sense_key,
   input wire logic [7:0]         sense_asc,
   input wire logic               release_req,
   input wire logic               xl_req
);
   wire take = cmd_valid && cmd_ready;
   wire rel  = take && (cdb_opcode == `OP_RELEASE6
                        || cdb_opcode == `OP_RELEASE10);
   wire diag = take && cdb_opcode == `OP_RECV_DIAG;
   // Block formats go to physical, physical formats go back to long block
   wire pair = ((sd_supplied_fmt == 3'h0 || sd_supplied_fmt == 3'h3)
                && sd_translate_fmt[2:1] == 2'h2)
               || (sd_supplied_fmt[2:1] == 2'h2 && sd_translate_fmt == 3'h3);
   wire bad  = status_valid && status_code == `STATUS_CHECK
               && sense_key == `SENSE_ILLEGAL && sense_asc == `ASC_INVALID_CDB;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   a_release_good: assert property (
      rel && !cdb_byte1[4] |-> ##2 status_valid && status_code == `STATUS_GOOD)
      else $error("release gave no good status");
   a_third_party_chk: assert property (rel && cdb_byte1[4] |-> ##2 bad)
      else $error("third party release not refused");
   a_resv_kept: assert property (
      rel && !holds_reservation |-> ##1 !release_req [*3])
      else $error("release requested with no reservation");
   a_bad_page: assert property (
      diag && cdb_byte1[0] && cdb_page != 8'h00 && cdb_page != 8'h40
      |-> ##2 bad)
      else $error("unsupported page not refused");
   a_pair_legal: assert property (sd_valid && pair |=> xl_req)
      else $error("legal format pair not translated");
   a_pair_illegal: assert property (sd_valid && !pair |=> !xl_req)
      else $error("illegal format pair translated");
   a_zero_alloc: assert property (
      diag && cdb_alloc_len == '0
      |=> !din_valid throughout (##[0:3] status_valid))
      else $error("zero allocation moved data");
   a_busy_take: assert property (take |=> !cmd_ready)
      else $error("ready right after a command");
endmodule : diag_release_props

bind diag_release_cmd diag_release_props #(.ALLOC_W(ALLOC_W)) props (
   .clock(clock), .reset(reset), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cdb_opcode(cdb_opcode), .cdb_byte1(cdb_byte1),
   .cdb_page(cdb_page), .cdb_alloc_len(cdb_alloc_len), .sd_valid(sd_valid),
   .sd_supplied_fmt(sd_supplied_fmt), .sd_translate_fmt(sd_translate_fmt),
   .holds_reservation(holds_reservation), .din_valid(din_valid),
   .status_valid(status_valid), .status_code(status_code),
   .sense_key(sense_key), .sense_asc(sense_asc),
   .release_req(release_req), .xl_req(xl_req));

// >>> dv/initiator_model.sv
`timescale 1ns/1ps
module initiator_model (
   input  wire logic         clock,
   input  wire logic         reset,
   input  wire logic         clear,
   input  wire logic         stall,
   input  wire logic         din_valid,
   input  wire logic [7:0]   din_data,
   output logic              din_ready,
   output logic      [127:0] rx_q,
   output logic      [4:0]   cnt_q
);
   // A slow initiator takes a byte only every other cycle
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         din_ready <= 1'b0;
      end else begin
         din_ready <= stall ? !din_ready : 1'b1;
      end
   end
   // Byte 0 lands in the top lane; the count caps so it cannot wrap
   always_ff @(posedge clock or posedge reset) begin
      if (reset || clear) begin
         rx_q  <= '0;
         cnt_q <= '0;
      end else if (din_valid && din_ready && cnt_q < 5'h10) begin
         rx_q[127 - 8*cnt_q -: 8] <= din_data;
         cnt_q                    <= cnt_q + 5'h1;
      end
   end
endmodule : initiator_model

// >>> dv/test_diag_release_cmd.sv
`timescale 1ns/1ps
`include "diag_cmd_regs.svh"
module test_diag_release_cmd;
   import diag_cmd_pkg::*;
   logic         clock = 1'b0;
   logic         reset = 1'b1;
   logic         cmd_valid = 1'b0;
   logic [7:0]   op = 8'h00, b1 = 8'h00, pg = 8'h00;
   logic [15:0]  alloc = 16'h0;
   logic         sd_valid = 1'b0, xl_valid = 1'b0, resv = 1'b0;
   logic [2:0]   sf = 3'h0, tf = 3'h0, fl = 3'h0;
   logic         clear = 1'b0, stall = 1'b0, rel_seen = 1'b0;
   logic         cmd_ready, din_valid, din_ready, status_valid, rreq, xl_req;
   logic [7:0]   din_data, status_code, sense_asc;
   logic [3:0]   sense_key;
   logic [63:0]  xl_req_addr;
   logic [2:0]   xl_req_fmt;
   logic [127:0] rx;
   logic [4:0]   rx_n;
   int           num_errors = 0;
   int           compares = 0;
   localparam logic [63:0] SA = 64'h0123456789abcdef, TA = 64'h00a1b2c3d4e5f607;

   always #5 clock = !clock;
   always @(posedge clock) if (rreq === 1'b1) rel_seen <= 1'b1;

   diag_release_cmd #(.ALLOC_W(16)) dut (.clock(clock), .reset(reset),
      .cmd_valid(cmd_valid), .cdb_opcode(op), .cdb_byte1(b1), .cdb_page(pg),
      .cdb_alloc_len(alloc), .sd_valid(sd_valid), .sd_page(`PAGE_TRANSLATE),
      .sd_supplied_fmt(sf), .sd_translate_fmt(tf), .sd_supplied_addr(SA),
      .xl_valid(xl_valid), .xl_inaccessible(fl[2]),
      .xl_spare_reassigned(fl[1]), .xl_in_nv_cache(fl[0]), .xl_addr(TA),
      .holds_reservation(resv), .cmd_ready(cmd_ready), .din_valid(din_valid),
      .din_data(din_data), .din_ready(din_ready),
      .status_valid(status_valid), .status_code(status_code),
      .sense_key(sense_key), .sense_asc(sense_asc), .release_req(rreq),
      .xl_req(xl_req), .xl_req_addr(xl_req_addr), .xl_req_fmt(xl_req_fmt));
   initiator_model host (.clock(clock), .reset(reset), .clear(clear),
      .stall(stall), .din_valid(din_valid), .din_data(din_data),
      .din_ready(din_ready), .rx_q(rx), .cnt_q(rx_n));

   ////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [127:0] got, input logic [127:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : check

   task automatic end_sim;
      if (num_errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_sim

   // Status codes hold after the pulse, so callers may read them later
   task automatic issue(input logic [7:0] o, c, p, input logic [15:0] a);
      int n;
      @(posedge clock);
      {clear, cmd_valid, rel_seen} <= 3'b110;
      {op, b1, pg, alloc} <= {o, c, p, a};
      @(posedge clock);
      {clear, cmd_valid} <= 2'b00;
      for (n = 0; n < 200 && status_valid !== 1'b1; n++) @(posedge clock) #1;
      check(status_valid, 1'b1);
   endtask : issue

   task automatic diag(input logic [7:0] c, p, input logic [15:0] a,
                       input logic [7:0] st, input logic [4:0] n,
                       input logic [111:0] ev);
      issue(`OP_RECV_DIAG, c, p, a);
      check(status_code, st);
      if (st == `STATUS_CHECK) check(sense_asc, `ASC_INVALID_CDB);
      check(rx_n, n);
      for (int i = 0; i < n; i++) check(rx[127-8*i -: 8], ev[111-8*i -: 8]);
   endtask : diag

   ////////////////////////////////////////////////////////////////////////
   task automatic t_release;
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         resv <= i[1];
         // Junk in the ignored id fields, extent kept clear
         issue(i[0] ? `OP_RELEASE10 : `OP_RELEASE6, i[2] ? 8'h10 : 8'h0e,
               8'ha5, 16'h0);
         check(status_code, i[2] ? `STATUS_CHECK : `STATUS_GOOD);
         check(rel_seen, i == 2 || i == 3);
         if (i[2]) check({sense_key, sense_asc}, 12'h524);
      end
   endtask : t_release

   task automatic t_pages;
      logic [111:0] ev;
      ev = {64'h00000004003f4042, 48'h0};
      stall <= 1'b1;
      diag(8'h01, `PAGE_SUPPORTED, 16'h10, `STATUS_GOOD, 5'd8, ev);
      diag(8'h01, 8'h00, 16'h3, `STATUS_GOOD, 5'd3, ev);
      diag(8'h01, 8'h00, 16'h0, `STATUS_GOOD, 5'd0, ev);
      diag(8'h01, 8'h41, 16'h10, `STATUS_CHECK, 5'd0, ev);
   endtask : t_pages

   task automatic t_xlate(input logic [2:0] s, t, f, input logic ok,
                          input logic [4:0] n, input logic [111:0] ev);
      @(posedge clock);
      {sd_valid, sf, tf} <= {1'b1, s, t};
      @(posedge clock);
      sd_valid <= 1'b0;
      #1;
      check(xl_req, ok);
      if (ok) begin
         check({xl_req_addr, xl_req_fmt}, {SA, t});
         @(posedge clock);
         {xl_valid, fl} <= {1'b1, f};
         @(posedge clock);
         xl_valid <= 1'b0;
      end
      // Page code differs from the last send diagnostic and must be ignored
      diag(8'h00, 8'h00, 16'h10, ok ? `STATUS_GOOD : `STATUS_CHECK, n, ev);
   endtask : t_xlate

   initial begin
      repeat (2) @(posedge clock);
      reset <= 1'b0;
      t_release();
      t_pages();
      t_xlate(3'h0, 3'h5, 3'h4, 1'b1, 5'd6, {48'h400000020085, 64'h0});
      t_xlate(3'h3, 3'h4, 3'h2, 1'b1, 5'd14, {48'h4000000a0344, TA});
      t_xlate(3'h5, 3'h3, 3'h0, 1'b1, 5'd14, {48'h4000000a0503, TA});
      t_xlate(3'h4, 3'h3, 3'h0, 1'b1, 5'd14, {48'h4000000a0403, TA});
      t_xlate(3'h0, 3'h5, 3'h1, 1'b1, 5'd14, {48'h4000000a0005, ~64'h0});
      t_xlate(3'h4, 3'h5, 3'h0, 1'b0, 5'd0, 112'h0);
      end_sim();
   end

   initial begin
      #100000;
      num_errors++;
      end_sim();
   end
endmodule : test_diag_release_cmd
